/* design/rdc_rs485_ctl.sv */
// rs-485 direction control and multidrop receive filtering of a uart
`timescale 1ns/1ps
`include "rdc_params.svh"
module rdc_rs485_ctl #(
	parameter int BIT_CYC = `RDC_BIT_CYC,
	parameter int FIFO_DEPTH = `RDC_FIFO_DEPTH
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] tx_data_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	output logic [7:0] rx_data_o,
	output logic rx_pe_o,
	output logic rx_fe_o,
	output logic rx_valid_o,
	input wire logic rx_ready_i,
	input wire logic rx_serial_i,
	output logic tx_serial_o,
	output logic rts_n_o,
	input wire logic direction_auto_i,
	input wire logic direction_invert_i,
	input wire logic multidrop_en_i,
	input wire logic receiver_off_i,
	input wire logic transmitter_off_i,
	input wire logic special_char_en_i,
	input wire logic [7:0] second_stop_char_value_i,
	input wire logic [2:0] line_control_parity_i,
	input wire logic modem_control_rts_i,
	input wire logic flow_ctl_en_i,
	input wire logic flow_rts_n_i,
	input wire logic line_status_ie_i,
	output logic line_status_event_o,
	output logic rx_overrun_o,
	output logic rx_auto_en_o,
	output logic tx_empty_o
);
	localparam int CW = $clog2(BIT_CYC);
	localparam logic [CW-1:0] FULL = CW'(BIT_CYC - 1);
	localparam logic [CW-1:0] HALF = CW'(BIT_CYC / 2 - 1);

	if (BIT_CYC < 4) begin : g_bad_bit
		$error("rdc_rs485_ctl needs at least 4 clocks per bit");
	end
	if (FIFO_DEPTH < 2) begin : g_bad_depth
		$error("rdc_rs485_ctl needs a fifo of at least 2 words");
	end

	rdc_stream_if #(.W(8)) tx_in ();
	rdc_stream_if #(.W(8)) tx_out ();
	rdc_stream_if #(.W(`RDC_RX_W)) rx_wr ();
	rdc_stream_if #(.W(`RDC_RX_W)) rx_rd ();

	logic tx_fifo_busy, tx_busy, tx_fire, dir_active, rts_auto_n, rts_n_d;
	logic rts_q, tx_empty_q;

	// host side of the transmit path
	assign tx_in.valid = tx_valid_i;
	assign tx_in.data = tx_data_i;
	assign tx_ready_o = tx_in.ready;
	assign tx_fire = tx_valid_i & tx_in.ready;

	// transmit fifo keeps filling while the serializer is held off
	rdc_fifo #(
		.W(8),
		.DEPTH(FIFO_DEPTH)
	) u_tx_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wr(tx_in),
		.rd(tx_out),
		.busy_o(tx_fifo_busy)
	);

	rdc_tx_ser #(
		.BIT_CYC(BIT_CYC)
	) u_tx_ser (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_s(tx_out),
		.line_control_parity_i(line_control_parity_i),
		.transmitter_off_i(transmitter_off_i),
		.tx_serial_o(tx_serial_o),
		.busy_o(tx_busy)
	);

	// direction source selection and polarity
	assign dir_active = tx_fire | tx_fifo_busy | tx_busy;
	assign rts_auto_n = direction_invert_i ? dir_active : !dir_active;
	assign rts_n_d = direction_auto_i ? rts_auto_n :
		flow_ctl_en_i ? flow_rts_n_i : !modem_control_rts_i;
	assign rts_n_o = rts_q;
	assign tx_empty_o = tx_empty_q;

	// registered direction pin and transmitter empty status
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rts_q <= `RDC_RTS_RST;
			tx_empty_q <= 1'b1;
		end else begin
			rts_q <= rts_n_d;
			tx_empty_q <= !dir_active;
		end
	end

	rdc_pkg::rdc_rx_state_e st_q, st_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic [3:0] idx_q, idx_d;
	logic [8:0] sh_q, sh_d;
	logic rx_s1_q, rx_s2_q, rx_en_q, rx_en_d, off_prev_q, ls_evt_q, ovr_q;
	logic tick, par_en, halt, char_done, abort, sh9, addr, match, auto_md;
	logic pe_calc, pe_bit, fe_bit, accept, host_off_rise;
	logic [3:0] last_idx;

	// serial input passes two flops before any logic sees it
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_s1_q <= `RDC_LINE_IDLE;
			rx_s2_q <= `RDC_LINE_IDLE;
		end else begin
			rx_s1_q <= rx_serial_i;
			rx_s2_q <= rx_s1_q;
		end
	end

	// receive decode
	assign tick = cnt_q == '0;
	assign par_en = line_control_parity_i[`RDC_LC_PEN];
	assign last_idx = par_en ? `RDC_RX_LAST_P : `RDC_RX_LAST;
	assign halt = receiver_off_i & !multidrop_en_i;
	assign char_done = (st_q == rdc_pkg::RX_STOP) & tick;
	assign abort = halt & (st_q == rdc_pkg::RX_BITS);
	assign sh9 = par_en & sh_q[8];
	assign addr = multidrop_en_i & sh9;
	assign match = sh_q[7:0] == second_stop_char_value_i;
	assign auto_md = multidrop_en_i & special_char_en_i;
	assign pe_calc = par_en & (sh_q[8] != rdc_pkg::ninth_bit(line_control_parity_i, sh_q[7:0]));
	assign pe_bit = auto_md ? sh9 : pe_calc;
	assign fe_bit = char_done & !rx_s2_q;
	assign host_off_rise = receiver_off_i & !off_prev_q;

	// which characters reach the receive fifo
	assign accept = abort ? 1'b1 :
		!char_done ? 1'b0 :
		!multidrop_en_i ? 1'b1 :
		auto_md ? (addr ? match : rx_en_q) :
		(addr | !receiver_off_i);
	assign rx_wr.valid = accept;
	assign rx_wr.data = {fe_bit, pe_bit, sh_q[7:0]};

	// automatic receiver enable: a match sets it, and set beats clear
	assign rx_en_d = (char_done & auto_md & addr & match) ? 1'b1 :
		(char_done & auto_md & addr) ? 1'b0 :
		host_off_rise ? 1'b0 : rx_en_q;

	// receive sequencer next state
	always_comb begin
		st_d = st_q;
		cnt_d = tick ? cnt_q : cnt_q - 1'b1;
		idx_d = idx_q;
		sh_d = sh_q;
		unique case (st_q)
			rdc_pkg::RX_IDLE: begin
				if (!rx_s2_q && !halt) begin
					st_d = rdc_pkg::RX_START;
					cnt_d = HALF;
					idx_d = '0;
					sh_d = '0;
				end
			end
			rdc_pkg::RX_START: begin
				if (tick) begin
					st_d = rx_s2_q ? rdc_pkg::RX_IDLE : rdc_pkg::RX_BITS;
					cnt_d = FULL;
				end
			end
			rdc_pkg::RX_BITS: begin
				if (halt) begin
					st_d = rdc_pkg::RX_IDLE;
				end else if (tick) begin
					sh_d[idx_q] = rx_s2_q;
					idx_d = idx_q + 1'b1;
					cnt_d = FULL;
					if (idx_q == last_idx)
						st_d = rdc_pkg::RX_STOP;
				end
			end
			rdc_pkg::RX_STOP: begin
				if (tick)
					st_d = rdc_pkg::RX_IDLE;
			end
		endcase
	end

	// receive sequencer registers
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_q <= rdc_pkg::RX_IDLE;
			cnt_q <= '0;
			idx_q <= '0;
			sh_q <= '0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			idx_q <= idx_d;
			sh_q <= sh_d;
		end
	end

	// receive status flops
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_en_q <= 1'b0;
			off_prev_q <= 1'b0;
			ls_evt_q <= 1'b0;
			ovr_q <= 1'b0;
		end else begin
			rx_en_q <= rx_en_d;
			off_prev_q <= receiver_off_i;
			ls_evt_q <= accept & rx_wr.ready & pe_bit & line_status_ie_i;
			ovr_q <= accept & !rx_wr.ready;
		end
	end

	// receive fifo; the line cannot be stalled, so a full fifo overruns
	rdc_fifo #(
		.W(`RDC_RX_W),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wr(rx_wr),
		.rd(rx_rd),
		.busy_o()
	);

	// host side of the receive path
	assign rx_rd.ready = rx_ready_i;
	assign rx_valid_o = rx_rd.valid;
	assign rx_data_o = rx_rd.data[7:0];
	assign rx_pe_o = rx_rd.data[`RDC_ENT_PE];
	assign rx_fe_o = rx_rd.data[`RDC_ENT_FE];
	assign line_status_event_o = ls_evt_q;
	assign rx_overrun_o = ovr_q;
	assign rx_auto_en_o = rx_en_q;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_rts_mcr;
		!direction_auto_i && !flow_ctl_en_i |=> rts_n_o == !$past(modem_control_rts_i);
	endproperty
	a_rts_mcr: assert property (p_rts_mcr) else $error("direction not from modem bit");

	property p_rts_flow;
		!direction_auto_i && flow_ctl_en_i |=> rts_n_o == $past(flow_rts_n_i);
	endproperty
	a_rts_flow: assert property (p_rts_flow) else $error("direction not from flow control");

	property p_rts_assert;
		direction_auto_i && !direction_invert_i && tx_fire |=> !rts_n_o;
	endproperty
	a_rts_assert: assert property (p_rts_assert) else $error("direction not asserted on write");

	property p_rts_inv;
		direction_auto_i && direction_invert_i && tx_fire |=> rts_n_o;
	endproperty
	a_rts_inv: assert property (p_rts_inv) else $error("inverted direction wrong on write");

	property p_rts_hold;
		direction_auto_i && !direction_invert_i && tx_busy |=> !rts_n_o && !tx_empty_o;
	endproperty
	a_rts_hold: assert property (p_rts_hold) else $error("direction released mid character");

	property p_rts_release;
		direction_auto_i && !direction_invert_i && !dir_active |=> rts_n_o && tx_empty_o;
	endproperty
	a_rts_release: assert property (p_rts_release) else $error("direction held when idle");

	property p_md_ignore;
		char_done && multidrop_en_i && !special_char_en_i && !addr && receiver_off_i |-> !accept;
	endproperty
	a_md_ignore: assert property (p_md_ignore) else $error("data stored while disabled");

	property p_md_addr;
		char_done && multidrop_en_i && !special_char_en_i && addr
			&& line_control_parity_i == `RDC_LC_FORCE0 |-> accept && pe_bit;
	endproperty
	a_md_addr: assert property (p_md_addr) else $error("address byte not flagged");

	property p_md_enabled;
		char_done && multidrop_en_i && !special_char_en_i && !receiver_off_i |-> accept;
	endproperty
	a_md_enabled: assert property (p_md_enabled) else $error("enabled receiver dropped byte");

	property p_ls_evt;
		accept && rx_wr.ready && pe_bit && line_status_ie_i |=> line_status_event_o;
	endproperty
	a_ls_evt: assert property (p_ls_evt) else $error("line status event missing");

	property p_auto_match;
		char_done && auto_md && addr && match |-> accept && pe_bit ##1 rx_auto_en_o;
	endproperty
	a_auto_match: assert property (p_auto_match) else $error("matching address not taken");

	property p_auto_drop;
		char_done && auto_md && addr && !match |-> !accept ##1 !rx_auto_en_o;
	endproperty
	a_auto_drop: assert property (p_auto_drop) else $error("foreign address not dropped");

	property p_auto_data;
		char_done && auto_md && !addr && !rx_en_q |-> !accept;
	endproperty
	a_auto_data: assert property (p_auto_data) else $error("data kept while not addressed");

	property p_halt;
		abort |-> accept ##1 st_q == rdc_pkg::RX_IDLE;
	endproperty
	a_halt: assert property (p_halt) else $error("receiver off not immediate");
endmodule : rdc_rs485_ctl

/* shared/rdc_params.svh */
// named constants of the rs-485 direction and multidrop block
`ifndef RDC_PARAMS_SVH
`define RDC_PARAMS_SVH
`define RDC_BIT_CYC 16
`define RDC_FIFO_DEPTH 8
`define RDC_LC_PEN 0
`define RDC_LC_EVEN 1
`define RDC_LC_FORCE 2
`define RDC_LC_FORCE0 3'h7
`define RDC_RX_W 10
`define RDC_ENT_PE 8
`define RDC_ENT_FE 9
`define RDC_RX_LAST 4'h7
`define RDC_RX_LAST_P 4'h8
`define RDC_TX_BITS 4'hA
`define RDC_TX_BITS_P 4'hB
`define RDC_LINE_IDLE 1'h1
`define RDC_RTS_RST 1'h1
`endif

/* shared/rdc_pkg.sv */
// shared types and helpers of the rs-485 direction and multidrop block
`include "rdc_params.svh"
package rdc_pkg;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} rdc_rx_state_e;
	typedef enum logic {TX_IDLE, TX_SHIFT} rdc_tx_state_e;

	// value of the ninth bit for a line-control parity field and a data byte
	function automatic logic ninth_bit(input logic [2:0] lc, input logic [7:0] d);
		if (lc[`RDC_LC_FORCE])
			return !lc[`RDC_LC_EVEN];
		else if (lc[`RDC_LC_EVEN])
			return ^d;
		else
			return ~^d;
	endfunction : ninth_bit
endpackage : rdc_pkg

/* shared/rdc_stream_if.sv */
// valid/ready word stream between the block's own modules
`timescale 1ns/1ps
interface rdc_stream_if #(
	parameter int W = 8
) ();
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : rdc_stream_if

/* design/rdc_fifo.sv */
// fifo with registered read data and registered ready
`timescale 1ns/1ps
`include "rdc_params.svh"
module rdc_fifo #(
	parameter int W = 8,
	parameter int DEPTH = `RDC_FIFO_DEPTH
) (
	input wire logic clk_i,
	input wire logic rst_i,
	rdc_stream_if.snk wr,
	rdc_stream_if.src rd,
	output logic busy_o
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("rdc_fifo depth must be a power of two of at least 2");
	end

	logic [W-1:0] mem_q [DEPTH];
	logic [W-1:0] out_q;
	logic [AW-1:0] wp_q, rp_q;
	logic [AW:0] cnt_q, cnt_d;
	logic rdy_q, ov_q, push, load;

	// handshakes and occupancy
	assign push = wr.valid & rdy_q;
	assign load = (cnt_q != '0) & (!ov_q | rd.ready);
	assign cnt_d = cnt_q + (AW + 1)'(push) - (AW + 1)'(load);
	assign wr.ready = rdy_q;
	assign rd.valid = ov_q;
	assign rd.data = out_q;
	assign busy_o = (cnt_q != '0) | ov_q;

	// storage, no reset needed
	always_ff @(posedge clk_i) begin
		if (push)
			mem_q[wp_q] <= wr.data;
	end

	// pointers, count and output register
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			rdy_q <= 1'b0;
			ov_q <= 1'b0;
			out_q <= '0;
		end else begin
			wp_q <= wp_q + AW'(push);
			rp_q <= rp_q + AW'(load);
			cnt_q <= cnt_d;
			rdy_q <= cnt_d != FULL;
			ov_q <= load | (ov_q & !rd.ready);
			if (load)
				out_q <= mem_q[rp_q];
		end
	end
endmodule : rdc_fifo

/* design/rdc_tx_ser.sv */
// transmit serializer: start, 8 data, optional ninth bit, stop
`timescale 1ns/1ps
`include "rdc_params.svh"
module rdc_tx_ser #(
	parameter int BIT_CYC = `RDC_BIT_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	rdc_stream_if.snk in_s,
	input wire logic [2:0] line_control_parity_i,
	input wire logic transmitter_off_i,
	output logic tx_serial_o,
	output logic busy_o
);
	localparam int CW = $clog2(BIT_CYC);
	localparam logic [CW-1:0] FULL = CW'(BIT_CYC - 1);

	if (BIT_CYC < 2) begin : g_bad_bit
		$error("rdc_tx_ser needs at least 2 clocks per bit");
	end

	rdc_pkg::rdc_tx_state_e st_q;
	logic [10:0] sh_q;
	logic [3:0] left_q;
	logic [CW-1:0] cnt_q;
	logic tx_q, take, tick, par_en, pbit;

	// a new character starts only when idle and not switched off
	assign in_s.ready = (st_q == rdc_pkg::TX_IDLE) & !transmitter_off_i;
	assign take = in_s.valid & in_s.ready;
	assign tick = cnt_q == '0;
	assign par_en = line_control_parity_i[`RDC_LC_PEN];
	assign pbit = par_en ? rdc_pkg::ninth_bit(line_control_parity_i, in_s.data) : 1'b1;
	assign busy_o = st_q == rdc_pkg::TX_SHIFT;
	assign tx_serial_o = tx_q;

	// shifting; a frame already begun always completes
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_q <= rdc_pkg::TX_IDLE;
			sh_q <= '1;
			left_q <= '0;
			cnt_q <= '0;
			tx_q <= `RDC_LINE_IDLE;
		end else if (take) begin
			st_q <= rdc_pkg::TX_SHIFT;
			sh_q <= {1'b1, pbit, in_s.data, 1'b0};
			left_q <= par_en ? `RDC_TX_BITS_P : `RDC_TX_BITS;
			cnt_q <= FULL;
			tx_q <= 1'b0;
		end else if (busy_o) begin
			cnt_q <= tick ? FULL : cnt_q - 1'b1;
			if (tick) begin
				sh_q <= {1'b1, sh_q[10:1]};
				left_q <= left_q - 1'b1;
				tx_q <= (left_q == 4'h1) ? `RDC_LINE_IDLE : sh_q[1];
				if (left_q == 4'h1)
					st_q <= rdc_pkg::TX_IDLE;
			end
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_tx_off;
		transmitter_off_i && !busy_o |=> !busy_o && tx_serial_o;
	endproperty
	a_tx_off: assert property (p_tx_off) else $error("transmitter started while off");
endmodule : rdc_tx_ser

/* testbench/rdc_station.sv */
// remote multidrop station: sends frames to the block and decodes its line output
`timescale 1ns/1ps
module rdc_station #(
	parameter int BIT_CYC = 4
) (
	input wire logic clk_i,
	input wire logic par_i,
	input wire logic tx_serial_i,
	output logic rx_serial_o,
	output logic [9:0] got_o,
	output logic got_valid_o
);
	logic [9:0] sh;

	// line rests at the idle mark level between frames
	initial rx_serial_o = 1'b1;

	// master frame: start, data lsb first, address marker, stop, two idle bits
	task automatic send(input logic [7:0] d, input logic nb);
		logic [12:0] f;
		f = {3'b111, nb, d, 1'b0};
		for (int i = 0; i < 13; i++) begin
			@(negedge clk_i);
			rx_serial_o = f[i];
			repeat (BIT_CYC - 1) @(negedge clk_i);
		end
	endtask : send

	// decode frames from the block, stop bit kept in the top bit
	initial begin
		got_valid_o = 1'b0;
		got_o = 10'h000;
		forever begin
			@(negedge tx_serial_i);
			repeat (BIT_CYC / 2) @(posedge clk_i);
			sh = 10'h000;
			for (int i = 0; i < 8 + par_i; i++) begin
				repeat (BIT_CYC) @(posedge clk_i);
				sh[i] = tx_serial_i;
			end
			repeat (BIT_CYC) @(posedge clk_i);
			sh[9] = tx_serial_i;
			got_o <= sh;
			got_valid_o <= 1'b1;
			@(posedge clk_i);
			got_valid_o <= 1'b0;
		end
	end
endmodule : rdc_station

/* testbench/rdc_rs485_ctl_test.sv */
// self-checking bench of the rs-485 direction and multidrop block
`timescale 1ns/1ps
module rdc_rs485_ctl_test;
	localparam int BC = 4;
	logic clk_i = 0, rst_i = 1, tx_valid_i = 0, rx_ready_i = 1, ok, exp;
	logic [7:0] tx_data_i = 8'h00, second_stop_char_value_i = 8'hA5, rx_data_o;
	logic direction_auto_i = 0, direction_invert_i = 0, modem_control_rts_i = 0;
	logic multidrop_en_i = 0, receiver_off_i = 0, transmitter_off_i = 0, special_char_en_i = 0;
	logic flow_ctl_en_i = 0, flow_rts_n_i = 1, line_status_ie_i = 1;
	logic [2:0] line_control_parity_i = 3'h0;
	logic tx_ready_o, rx_pe_o, rx_fe_o, rx_valid_o, rx_serial_i, tx_serial_o, rts_n_o;
	logic line_status_event_o, rx_overrun_o, rx_auto_en_o, tx_empty_o, got_valid;
	logic [9:0] got;
	logic [7:0] seed = 8'h57, rseed = 8'h57;
	logic [9:0] rx_exp_q[$];
	logic [7:0] tx_exp_q[$];
	int n_fail = 0, n_checks = 0, n_evt = 0, n_evt_exp = 0, n_ovr = 0, n;

	rdc_rs485_ctl #(.BIT_CYC(BC), .FIFO_DEPTH(8)) i_dut (.clk_i, .rst_i, .tx_data_i,
		.tx_valid_i, .tx_ready_o, .rx_data_o, .rx_pe_o, .rx_fe_o, .rx_valid_o, .rx_ready_i,
		.rx_serial_i, .tx_serial_o, .rts_n_o, .direction_auto_i, .direction_invert_i,
		.multidrop_en_i, .receiver_off_i, .transmitter_off_i, .special_char_en_i,
		.second_stop_char_value_i, .line_control_parity_i, .modem_control_rts_i,
		.flow_ctl_en_i, .flow_rts_n_i, .line_status_ie_i, .line_status_event_o,
		.rx_overrun_o, .rx_auto_en_o, .tx_empty_o);

	rdc_station #(.BIT_CYC(BC)) i_sta (.clk_i(clk_i), .par_i(line_control_parity_i[0]),
		.tx_serial_i(tx_serial_o), .rx_serial_o(rx_serial_i), .got_o(got),
		.got_valid_o(got_valid));

	// clock and random host stall on the receive side
	always #5 clk_i = ~clk_i;
	always @(negedge clk_i) begin
		rseed = lfsr(rseed);
		rx_ready_i = rseed[0] | rseed[2];
	end

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	task automatic check(input logic [9:0] seen, input logic [9:0] want);
		n_checks++;
		if (seen !== want) begin
			n_fail++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check

	// scoreboard: the oldest note is taken whenever a result shows up
	always @(posedge clk_i) begin
		if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1)
			check({rx_fe_o, rx_pe_o, rx_data_o}, rx_exp_q.size() ? rx_exp_q.pop_front() : 10'h3FF);
		if (got_valid === 1'b1)
			check(got, tx_exp_q.size() ? {2'b10, tx_exp_q.pop_front()} : 10'h000);
		if (line_status_event_o === 1'b1)
			n_evt++;
		if (rx_overrun_o === 1'b1)
			n_ovr++;
	end

	// one host write, retried for up to tries cycles
	task automatic put(input logic [7:0] d, input int tries, output logic acc);
		@(negedge clk_i);
		tx_valid_i = 1'b1;
		tx_data_i = d;
		acc = 1'b0;
		for (int i = 0; i < tries && !acc; i++) begin
			@(posedge clk_i);
			acc = (tx_ready_o === 1'b1);
		end
		if (acc)
			tx_exp_q.push_back(d);
	endtask : put

	// wait for the transmit side to drain, direction must stay active meanwhile
	task automatic drain(input logic act);
		for (int i = 0; i < 3000; i++) begin
			@(negedge clk_i);
			if (tx_empty_o === 1'b1)
				break;
			check(10'(rts_n_o), 10'(act));
		end
		repeat (3) @(negedge clk_i);
		check({8'h00, rts_n_o, tx_empty_o}, {8'h00, !act, 1'b1});
	endtask : drain

	// remote frame; a note is made first when the block should store it
	task automatic frame(input logic [7:0] d, input logic nb, input logic keep);
		if (keep) begin
			rx_exp_q.push_back({1'b0, nb, d});
			n_evt_exp += int'(nb & line_status_ie_i);
		end
		i_sta.send(d, nb);
		repeat (4) @(negedge clk_i);
	endtask : frame

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up

	// watchdog against a hung handshake
	initial begin
		repeat (30000) @(posedge clk_i);
		n_fail++;
		wrap_up();
	end

	// main sequence
	initial begin
		repeat (16) @(posedge clk_i);
		@(negedge clk_i);
		rst_i = 1'b0;
		repeat (3) @(negedge clk_i);
		check({6'h00, rts_n_o, tx_empty_o, rx_valid_o, rx_auto_en_o}, 10'h00C);
		// every direction source combination while idle
		for (int k = 0; k < 32; k++) begin
			{direction_auto_i, direction_invert_i, modem_control_rts_i, flow_ctl_en_i,
				flow_rts_n_i} = 5'(k);
			repeat (3) @(negedge clk_i);
			exp = direction_auto_i ? !direction_invert_i :
				(flow_ctl_en_i ? flow_rts_n_i : !modem_control_rts_i);
			check(10'(rts_n_o), 10'(exp));
		end
		// auto direction with back-to-back characters, both polarities
		for (int inv = 0; inv < 2; inv++) begin
			{direction_auto_i, direction_invert_i, modem_control_rts_i, flow_ctl_en_i} =
				{1'b1, 1'(inv), 2'b10};
			repeat (3) begin
				seed = lfsr(seed);
				put(seed, 100, ok);
				check(10'(ok), 10'h001);
			end
			@(negedge clk_i);
			tx_valid_i = 1'b0;
			drain(1'(inv));
		end
		// fill the transmit fifo while the transmitter is off
		direction_invert_i = 1'b0;
		transmitter_off_i = 1'b1;
		n = 0;
		do begin
			seed = lfsr(seed);
			put(seed, 1, ok);
			n += ok;
		end while (ok && n < 12);
		@(negedge clk_i);
		tx_valid_i = 1'b0;
		check(10'(n >= 8 && n < 12), 10'h001);
		repeat (60) @(negedge clk_i);
		check({8'h00, tx_serial_o, rts_n_o}, 10'h002);
		transmitter_off_i = 1'b0;
		drain(1'b0);
		check(10'(tx_exp_q.size()), 10'h000);
		// plain mode: a whole byte, then a byte cut short by receiver off
		rx_exp_q.push_back(10'h096);
		frame(8'h96, 1'b1, 1'b0);
		rx_exp_q.push_back(10'h000);
		fork
			frame(8'h69, 1'b1, 1'b0);
			begin
				repeat (6) @(negedge clk_i);
				receiver_off_i = 1'b1;
			end
		join
		// software-managed multidrop with forced-zero parity
		{multidrop_en_i, line_control_parity_i, receiver_off_i} = {1'b1, 3'h7, 1'b1};
		repeat (4) @(negedge clk_i);
		frame(8'h31, 1'b0, 1'b0);
		frame(8'h42, 1'b1, 1'b1);
		receiver_off_i = 1'b0;
		frame(8'h53, 1'b0, 1'b1);
		line_status_ie_i = 1'b0;
		frame(8'h64, 1'b1, 1'b1);
		line_status_ie_i = 1'b1;
		receiver_off_i = 1'b1;
		frame(8'h75, 1'b0, 1'b0);
		// automatic address detection against the stored station address
		{special_char_en_i, receiver_off_i} = 2'b10;
		check(10'(rx_auto_en_o), 10'h000);
		frame(8'h11, 1'b0, 1'b0);
		frame(8'h5A, 1'b1, 1'b0);
		frame(8'hA5, 1'b1, 1'b1);
		check(10'(rx_auto_en_o), 10'h001);
		frame(8'h22, 1'b0, 1'b1);
		frame(8'hA5, 1'b1, 1'b1);
		frame(8'h3C, 1'b1, 1'b0);
		check(10'(rx_auto_en_o), 10'h000);
		frame(8'h44, 1'b0, 1'b0);
		for (int i = 0; i < 200 && rx_exp_q.size() != 0; i++)
			@(negedge clk_i);
		repeat (20) @(negedge clk_i);
		check(10'(rx_exp_q.size()), 10'h000);
		check(10'(n_evt), 10'(n_evt_exp));
		check(10'(n_ovr), 10'h000);
		wrap_up();
	end
endmodule : rdc_rs485_ctl_test
